// ---- inc/tmoc_regs.svh ----
// register offsets, field positions, reset values and codes of the timer compare block
// assumes inclusion by bare name from the design file and the testbench
`ifndef TMOC_REGS_SVH
`define TMOC_REGS_SVH
// byte offsets on the apb slave
`define TMOC_CTRL_OFS     12'h000
`define TMOC_CNT_OFS      12'h004
`define TMOC_CMP_OFS      12'h008
`define TMOC_FLAG_OFS     12'h00C
`define TMOC_IEN_OFS      12'h010
`define TMOC_FORCE_OFS    12'h014
`define TMOC_STAT_OFS     12'h018
// ctrl field positions
`define TMOC_CTRL_WGM_LSB 0
`define TMOC_CTRL_COM_LSB 2
`define TMOC_CTRL_CS_LSB  4
`define TMOC_CTRL_DDR_BIT 7
`define TMOC_CTRL_PORT_BIT 8
// flag bits (also interrupt enable bits)
`define TMOC_FLAG_OVF_BIT 0
`define TMOC_FLAG_CMP_BIT 1
// force strobe bit
`define TMOC_FORCE_BIT    0
// stat bits
`define TMOC_STAT_WAVE_BIT 0
`define TMOC_STAT_BLK_BIT  1
`define TMOC_STAT_DIR_BIT  2
// reset values
`define TMOC_CTRL_RST     9'h000
`define TMOC_CNT_RST      8'h00
`define TMOC_CMP_RST      8'h00
// counter extremes
`define TMOC_BOTTOM       8'h00
`define TMOC_MAX          8'hFF
// waveform mode codes
`define TMOC_WGM_NORMAL   2'h0
`define TMOC_WGM_PCPWM    2'h1
`define TMOC_WGM_CTC      2'h2
`define TMOC_WGM_FPWM     2'h3
// compare output action codes
`define TMOC_COM_NONE     2'h0
`define TMOC_COM_TOGGLE   2'h1
`define TMOC_COM_CLEAR    2'h2
`define TMOC_COM_SET      2'h3
`endif

// ---- inc/tmoc_pkg.sv ----
// types shared by the timer compare block
// assumes tmoc_regs.svh on the include path
package tmoc_pkg;
  // apb request as one bundle
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } tmoc_apb_req_type;

  // pin drive bundle
  typedef struct packed {
    logic out_val;
    logic out_en;
  } tmoc_pin_type;

  // counter direction for phase correct operation
  typedef enum logic {
    TMOC_UP,
    TMOC_DOWN
  } tmoc_dir_type;
endpackage : tmoc_pkg

// ---- hdl/tmoc_timer.sv ----
// 8-bit timer/counter with output compare, compare match output and apb registers
// assumes an apb master on pclk and a timer clock enable pulse from a prescaler
`timescale 1ns/1ps
`include "tmoc_regs.svh"

module tmoc_timer
  import tmoc_pkg::*;
(
  // apb slave
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // timer clock enable from the prescaler, same clock domain
  input  wire logic        timer_tick,
  // interrupt service acknowledges
  input  wire logic        compare_irq_ack,
  input  wire logic        overflow_irq_ack,
  // interrupt requests
  output logic             compare_irq,
  output logic             overflow_irq,
  // output compare pin
  output logic             pin_out,
  output logic             pin_oe
);

  ////////////////////////////////////////////////////////////////////////////
  // register state
  tmoc_apb_req_type req;
  logic [1:0]   waveform_mode_select_reg;
  logic [1:0]   compare_output_action_reg;
  logic [2:0]   clock_select_field_reg;
  logic         output_pin_direction_reg;
  logic         port_value_reg;
  logic [7:0]   counter_value_reg;
  logic [7:0]   compare_value_reg;
  logic [7:0]   compare_buffer_reg;
  logic         compare_match_flag_reg;
  logic         overflow_flag_reg;
  logic [1:0]   irq_enable_reg;
  logic         waveform_output_state_reg;
  logic         block_reg;
  tmoc_dir_type dir_reg;

  logic         wr_en;
  logic         rd_en;
  logic         tick;
  logic         pwm_mode;
  logic         raw_match;
  logic         match;
  logic         cnt_wr;
  logic         force_wr;
  logic         at_top;
  logic         at_bottom;
  logic [7:0]   counter_value_next;
  logic         wave_next;

  // decode of an offset into a hit, used by read and write paths
  function automatic logic hit(input logic [11:0] addr, input logic [11:0] ofs);
    hit = (addr == ofs);
  endfunction : hit

  // pwm modes share the buffered compare value
  function automatic logic is_pwm(input logic [1:0] wgm);
    is_pwm = (wgm == `TMOC_WGM_PCPWM) || (wgm == `TMOC_WGM_FPWM);
  endfunction : is_pwm

  assign req      = '{psel, penable, pwrite, paddr, pwdata};
  assign wr_en    = req.psel && req.penable && req.pwrite;
  assign rd_en    = req.psel && !req.penable && !req.pwrite;
  assign pwm_mode = is_pwm(waveform_mode_select_reg);
  // no timer clock while the clock select field is zero
  assign tick     = timer_tick && (clock_select_field_reg != 3'h0);
  assign cnt_wr   = wr_en && hit(req.paddr, `TMOC_CNT_OFS);
  assign force_wr = wr_en && hit(req.paddr, `TMOC_FORCE_OFS) && req.pwdata[`TMOC_FORCE_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // comparator, blocked for one timer clock after a counter write
  assign raw_match = (counter_value_reg == compare_value_reg);
  assign match     = raw_match && !block_reg;

  // top is an unblocked match in clear-on-match, max otherwise
  assign at_top    = (waveform_mode_select_reg == `TMOC_WGM_CTC) ? match
                   : (counter_value_reg == `TMOC_MAX);
  assign at_bottom = (counter_value_reg == `TMOC_BOTTOM);

  // block stays armed until a timer clock passes, even while stopped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      block_reg <= 1'b0;
    end else if (cnt_wr) begin
      block_reg <= 1'b1;
    end else if (tick) begin
      block_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // counting sequence depends on the waveform mode, and in clear-on-match also on the compare value
  always_comb begin
    counter_value_next = counter_value_reg;
    case (waveform_mode_select_reg)
      `TMOC_WGM_NORMAL: begin
        counter_value_next = counter_value_reg + 8'h01;
      end
      `TMOC_WGM_CTC: begin
        // a blocked match does not clear; below-count compare misses and wraps
        counter_value_next = at_top ? `TMOC_BOTTOM : counter_value_reg + 8'h01;
      end
      `TMOC_WGM_FPWM: begin
        counter_value_next = counter_value_reg + 8'h01;
      end
      `TMOC_WGM_PCPWM: begin
        counter_value_next = (dir_reg == TMOC_UP) ? counter_value_reg + 8'h01
                                                  : counter_value_reg - 8'h01;
      end
      default: begin
        counter_value_next = counter_value_reg;
      end
    endcase
  end

  // software write wins over counting
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      counter_value_reg <= `TMOC_CNT_RST;
    end else if (cnt_wr) begin
      counter_value_reg <= req.pwdata[7:0];
    end else if (tick) begin
      counter_value_reg <= counter_value_next;
    end
  end

  // direction for phase correct; turns at max and bottom
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dir_reg <= TMOC_UP;
    end else if (waveform_mode_select_reg != `TMOC_WGM_PCPWM) begin
      dir_reg <= TMOC_UP;
    end else if (tick && !cnt_wr) begin
      if (counter_value_next == `TMOC_MAX) begin
        dir_reg <= TMOC_DOWN;
      end else if (counter_value_next == `TMOC_BOTTOM) begin
        dir_reg <= TMOC_UP;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // compare value: buffer copy in pwm modes, direct otherwise
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      compare_buffer_reg <= `TMOC_CMP_RST;
    end else if (wr_en && hit(req.paddr, `TMOC_CMP_OFS)) begin
      compare_buffer_reg <= req.pwdata[7:0];
    end
  end

  // active copy follows the buffer only at max when buffered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      compare_value_reg <= `TMOC_CMP_RST;
    end else if (!pwm_mode) begin
      if (wr_en && hit(req.paddr, `TMOC_CMP_OFS)) begin
        compare_value_reg <= req.pwdata[7:0];
      end
    end else if (tick) begin
      // fast pwm loads at max, phase correct at max too (top of the slope)
      if (counter_value_reg == `TMOC_MAX) begin
        compare_value_reg <= compare_buffer_reg;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // flags: hardware set wins over any clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      compare_match_flag_reg <= 1'b0;
    end else if (tick && match) begin
      compare_match_flag_reg <= 1'b1;
    end else if (compare_irq_ack ||
                 (wr_en && hit(req.paddr, `TMOC_FLAG_OFS) && req.pwdata[`TMOC_FLAG_CMP_BIT])) begin
      compare_match_flag_reg <= 1'b0;
    end
  end

  // overflow: counter becoming zero from max (normal, ctc, fast) or at bottom (pc)
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      overflow_flag_reg <= 1'b0;
    end else if (tick && !cnt_wr && !at_bottom &&
                 counter_value_next == `TMOC_BOTTOM &&
                 (waveform_mode_select_reg == `TMOC_WGM_PCPWM ||
                  counter_value_reg == `TMOC_MAX)) begin
      overflow_flag_reg <= 1'b1;
    end else if (overflow_irq_ack ||
                 (wr_en && hit(req.paddr, `TMOC_FLAG_OFS) && req.pwdata[`TMOC_FLAG_OVF_BIT])) begin
      overflow_flag_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // waveform output state; action read live, so a new setting applies at once
  always_comb begin
    wave_next = waveform_output_state_reg;
    if (!pwm_mode) begin
      if ((tick && match) || force_wr) begin
        case (compare_output_action_reg)
          `TMOC_COM_NONE:   wave_next = waveform_output_state_reg;
          `TMOC_COM_TOGGLE: wave_next = !waveform_output_state_reg;
          `TMOC_COM_CLEAR:  wave_next = 1'b0;
          `TMOC_COM_SET:    wave_next = 1'b1;
          default:          wave_next = waveform_output_state_reg;
        endcase
      end
    end else if (tick) begin
      case (compare_output_action_reg)
        `TMOC_COM_TOGGLE: begin
          if (match && waveform_mode_select_reg == `TMOC_WGM_FPWM) begin
            wave_next = !waveform_output_state_reg;
          end
        end
        `TMOC_COM_CLEAR, `TMOC_COM_SET: begin
          // non-inverted clears on match (up), sets at bottom (fast) or match (down)
          if (match) begin
            wave_next = (waveform_mode_select_reg == `TMOC_WGM_PCPWM && dir_reg == TMOC_DOWN)
                      ^ compare_output_action_reg[0];
          end else if (waveform_mode_select_reg == `TMOC_WGM_FPWM &&
                       counter_value_reg == `TMOC_MAX) begin
            wave_next = !compare_output_action_reg[0];
          end
        end
        default: begin
          wave_next = waveform_output_state_reg;
        end
      endcase
    end
  end

  // never reset by a mode change, only by presetn
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      waveform_output_state_reg <= 1'b0;
    end else begin
      waveform_output_state_reg <= wave_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      waveform_mode_select_reg  <= 2'h0;
      compare_output_action_reg <= `TMOC_COM_NONE;
      clock_select_field_reg    <= 3'h0;
      output_pin_direction_reg  <= 1'b0;
      port_value_reg            <= 1'b0;
    end else if (wr_en && hit(req.paddr, `TMOC_CTRL_OFS)) begin
      waveform_mode_select_reg  <= req.pwdata[`TMOC_CTRL_WGM_LSB +: 2];
      compare_output_action_reg <= req.pwdata[`TMOC_CTRL_COM_LSB +: 2];
      clock_select_field_reg    <= req.pwdata[`TMOC_CTRL_CS_LSB +: 3];
      output_pin_direction_reg  <= req.pwdata[`TMOC_CTRL_DDR_BIT];
      port_value_reg            <= req.pwdata[`TMOC_CTRL_PORT_BIT];
    end
  end

  // interrupt enables
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_enable_reg <= 2'h0;
    end else if (wr_en && hit(req.paddr, `TMOC_IEN_OFS)) begin
      irq_enable_reg <= req.pwdata[1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs from flip-flops: one cycle behind the flags and waveform state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      compare_irq  <= 1'b0;
      overflow_irq <= 1'b0;
      pin_out      <= 1'b0;
      pin_oe       <= 1'b0;
    end else begin
      compare_irq  <= compare_match_flag_reg && irq_enable_reg[`TMOC_FLAG_CMP_BIT];
      overflow_irq <= overflow_flag_reg && irq_enable_reg[`TMOC_FLAG_OVF_BIT];
      // override only the value; direction always from the direction bit
      pin_out      <= (compare_output_action_reg != `TMOC_COM_NONE)
                    ? waveform_output_state_reg : port_value_reg;
      pin_oe       <= output_pin_direction_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb read data, captured in setup so access phase answers with no wait
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
      pready  <= 1'b0;
    end else begin
      pready  <= req.psel && !req.penable;
      pslverr <= 1'b0;
      if (req.psel && !req.penable) begin
        pslverr <= !(hit(req.paddr, `TMOC_CTRL_OFS) || hit(req.paddr, `TMOC_CNT_OFS) ||
                     hit(req.paddr, `TMOC_CMP_OFS) || hit(req.paddr, `TMOC_FLAG_OFS) ||
                     hit(req.paddr, `TMOC_IEN_OFS) || hit(req.paddr, `TMOC_FORCE_OFS) ||
                     hit(req.paddr, `TMOC_STAT_OFS));
      end
      if (rd_en) begin
        prdata <= 32'h0000_0000;
        case (req.paddr)
          `TMOC_CTRL_OFS: prdata[8:0] <= {port_value_reg, output_pin_direction_reg,
                                          clock_select_field_reg, compare_output_action_reg,
                                          waveform_mode_select_reg};
          `TMOC_CNT_OFS:  prdata[7:0] <= counter_value_reg;
          `TMOC_CMP_OFS:  prdata[7:0] <= pwm_mode ? compare_buffer_reg
                                                  : compare_value_reg;
          `TMOC_FLAG_OFS: prdata[1:0] <= {compare_match_flag_reg, overflow_flag_reg};
          `TMOC_IEN_OFS:  prdata[1:0] <= irq_enable_reg;
          `TMOC_STAT_OFS: prdata[2:0] <= {dir_reg == TMOC_DOWN, block_reg,
                                          waveform_output_state_reg};
          default:        prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

endmodule : tmoc_timer

// ---- tb/tmoc_sva.sv ----
// port checker for the timer compare block
// assumes one pclk domain and binding onto tmoc_timer
`timescale 1ns/1ps
module tmoc_sva (
  // apb side
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // timer side
  input wire logic        timer_tick,
  input wire logic        compare_irq_ack,
  input wire logic        overflow_irq_ack,
  input wire logic        compare_irq,
  input wire logic        overflow_irq,
  input wire logic        pin_out,
  input wire logic        pin_oe
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////////////////////////////////////////
  // causes: a write, a tick or an ack are the only events that move the outputs
  logic wr;
  logic ev_c;
  logic ev_o;
  logic ev_p;
  assign wr   = psel && penable && pwrite;
  assign ev_c = compare_irq_ack || wr;
  assign ev_o = overflow_irq_ack || wr;
  assign ev_p = timer_tick || wr;
  ////////////////////////////////////////////////////////////////////////////
  a_ready_after_setup: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  a_ready_one_pulse: assert property (pready |-> psel && penable ##1 !pready)
    else $error("ready outside access or too long");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_err_reads_zero: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  a_cmp_irq_cause: assert property ($rose(compare_irq) |-> $past(ev_p, 1) || $past(ev_p, 2))
    else $error("compare irq rose without cause");
  a_cmp_irq_clear: assert property ($fell(compare_irq) |-> $past(ev_c, 1) || $past(ev_c, 2))
    else $error("compare irq fell without cause");
  a_ovf_irq_clear: assert property ($fell(overflow_irq) |-> $past(ev_o, 1) || $past(ev_o, 2))
    else $error("overflow irq fell without cause");
  a_oe_by_write: assert property ($changed(pin_oe) |-> $past(wr, 1) || $past(wr, 2))
    else $error("pin direction moved without write");
  a_pin_by_event: assert property ($changed(pin_out) |-> $past(ev_p, 1) || $past(ev_p, 2))
    else $error("pin moved without tick or write");
  // main scenarios
  c_cmp_irq: cover property ($rose(compare_irq));
  c_ovf_irq: cover property ($rose(overflow_irq));
  c_pin_move: cover property ($changed(pin_out) && pin_oe);
endmodule : tmoc_sva

bind tmoc_timer tmoc_sva u_sva (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .timer_tick(timer_tick), .compare_irq_ack(compare_irq_ack),
  .overflow_irq_ack(overflow_irq_ack), .compare_irq(compare_irq),
  .overflow_irq(overflow_irq), .pin_out(pin_out), .pin_oe(pin_oe));

// ---- tb/tb.sv ----
// self-checking bench for the timer compare block
// assumes tmoc_pkg compiled first and tmoc_regs.svh on the include path
`timescale 1ns/1ps
`include "tmoc_regs.svh"
module tb;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic        timer_tick = 0, c_ack = 0, o_ack = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata;
  logic        pready, pslverr, compare_irq, overflow_irq, pin_out, pin_oe;
  int          n_fail = 0, n_checks = 0, cyc = 0;
  // 200 MHz clock
  always #2.5 pclk = ~pclk;
  tmoc_timer u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .timer_tick(timer_tick), .compare_irq_ack(c_ack),
    .overflow_irq_ack(o_ack), .compare_irq(compare_irq), .overflow_irq(overflow_irq),
    .pin_out(pin_out), .pin_oe(pin_oe));
  //////////////////////////////////////////////////////////////////////////////
  task tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : tally_and_finish
  // hang guard, the run needs well under 3000 cycles
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 8000) begin
      n_fail++;
      $display("BAD %0t timeout", $time);
      tally_and_finish;
    end
  end
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %0t seen %h want %h", $time, seen, exp);
    end
  endtask : chk
  // one apb transfer, held until ready is seen high
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
           output logic [31:0] q, output logic e);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // no wait-state limit of its own; the hang guard ends a stuck transfer
    do begin @(posedge pclk); end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, d, q, e);
  endtask : wr
  task rd(input logic [11:0] a, input logic [31:0] exp, input logic [31:0] m);
    logic [31:0] q;
    logic        e;
    apb(1'b0, a, 32'h0, q, e);
    chk(q & m, exp);
  endtask : rd
  task tick(input int n);
    repeat (n) begin
      @(posedge pclk); timer_tick <= 1'b1;
      @(posedge pclk); timer_tick <= 1'b0;
    end
  endtask : tick
  task ack(input logic o);
    @(posedge pclk); o_ack <= o; c_ack <= !o;
    @(posedge pclk); o_ack <= 1'b0; c_ack <= 1'b0;
    repeat (3) @(posedge pclk);
  endtask : ack
  function automatic logic [31:0] cfg(input logic [1:0] m, input logic [1:0] a,
                                      input logic [2:0] c, input logic d, input logic p);
    cfg = 32'h0;
    cfg[8:0] = {p, d, c, a, m};
  endfunction : cfg
  //////////////////////////////////////////////////////////////////////////////
  task s_reset;
    logic [31:0] q;
    logic        e;
    for (int i = 0; i < 7; i++) rd(12'(4 * i), 32'h0, 32'hFFFF_FFFF);
    chk({30'h0, pin_out, pin_oe}, 32'h0);
    apb(1'b0, 12'h01C, 32'h0, q, e);
    chk({q[30:0], e}, 32'h1);
  endtask : s_reset
  // set, clear, toggle by force, then a plain match with action zero
  task s_force;
    logic [1:0] act [3];
    logic       exp [3];
    act = '{`TMOC_COM_SET, `TMOC_COM_CLEAR, `TMOC_COM_TOGGLE};
    exp = '{1'b1, 1'b0, 1'b1};
    wr(`TMOC_CNT_OFS, 32'h0000_0040);
    for (int i = 0; i < 3; i++) begin
      // pin enabled only once the first force has set the waveform state
      wr(`TMOC_CTRL_OFS, cfg(`TMOC_WGM_NORMAL, act[i], 3'h0, i > 0, 1'b0));
      wr(`TMOC_FORCE_OFS, 32'h1);
      rd(`TMOC_STAT_OFS, {31'h0, exp[i]}, 32'h1);
      chk({30'h0, pin_out, pin_oe}, {30'h0, exp[i], i > 0});
    end
    rd(`TMOC_FLAG_OFS, 32'h0, 32'h3);
    rd(`TMOC_CNT_OFS, 32'h0000_0040, 32'h0000_00FF);
    wr(`TMOC_CTRL_OFS, cfg(`TMOC_WGM_NORMAL, `TMOC_COM_NONE, 3'h0, 1'b1, 1'b0));
    rd(`TMOC_CTRL_OFS, 32'h0000_0080, 32'h0000_01FF);
    chk({31'h0, pin_out}, 32'h0);
    wr(`TMOC_CTRL_OFS, cfg(`TMOC_WGM_NORMAL, `TMOC_COM_NONE, 3'h1, 1'b1, 1'b1));
    wr(`TMOC_CMP_OFS, 32'h0000_000B);
    wr(`TMOC_CNT_OFS, 32'h0000_000A);
    chk({31'h0, pin_out}, 32'h1);
    tick(2);
    rd(`TMOC_CNT_OFS, 32'h0000_000C, 32'h0000_00FF);
    rd(`TMOC_FLAG_OFS, 32'h2, 32'h2);
    rd(`TMOC_STAT_OFS, 32'h1, 32'h1);
    wr(`TMOC_CTRL_OFS, cfg(`TMOC_WGM_CTC, `TMOC_COM_NONE, 3'h1, 1'b1, 1'b0));
    rd(`TMOC_STAT_OFS, 32'h1, 32'h1);
  endtask : s_force
  task s_ctc;
    wr(`TMOC_FLAG_OFS, 32'h3);
    wr(`TMOC_CMP_OFS, 32'h2);
    wr(`TMOC_CNT_OFS, 32'h0);
    wr(`TMOC_CTRL_OFS, cfg(`TMOC_WGM_CTC, `TMOC_COM_TOGGLE, 3'h1, 1'b1, 1'b0));
    tick(2);
    rd(`TMOC_CNT_OFS, 32'h2, 32'h0000_00FF);
    rd(`TMOC_FLAG_OFS, 32'h0, 32'h2);
    tick(1);
    rd(`TMOC_CNT_OFS, 32'h0, 32'h0000_00FF);
    rd(`TMOC_FLAG_OFS, 32'h2, 32'h2);
    rd(`TMOC_STAT_OFS, 32'h0, 32'h1);
    chk({31'h0, pin_out}, 32'h0);
    wr(`TMOC_IEN_OFS, 32'h2);
    repeat (3) @(posedge pclk);
    chk({31'h0, compare_irq}, 32'h1);
    ack(1'b0);
    chk({31'h0, compare_irq}, 32'h0);
    rd(`TMOC_FLAG_OFS, 32'h0, 32'h2);
    wr(`TMOC_CTRL_OFS, cfg(`TMOC_WGM_CTC, `TMOC_COM_SET, 3'h1, 1'b1, 1'b0));
    tick(3);
    rd(`TMOC_STAT_OFS, 32'h1, 32'h1);
    rd(`TMOC_CNT_OFS, 32'h0, 32'h0000_00FF);
    wr(`TMOC_FLAG_OFS, 32'h2);
    rd(`TMOC_FLAG_OFS, 32'h0, 32'h2);
    wr(`TMOC_IEN_OFS, 32'h0);
    wr(`TMOC_CNT_OFS, 32'h5);
    tick(251);
    rd(`TMOC_CNT_OFS, 32'h0, 32'h0000_00FF);
    rd(`TMOC_FLAG_OFS, 32'h1, 32'h3);
  endtask : s_ctc
  task s_normal;
    wr(`TMOC_CTRL_OFS, cfg(`TMOC_WGM_NORMAL, `TMOC_COM_NONE, 3'h1, 1'b0, 1'b0));
    wr(`TMOC_FLAG_OFS, 32'h3);
    wr(`TMOC_IEN_OFS, 32'h1);
    wr(`TMOC_CNT_OFS, 32'h0000_00FE);
    tick(1);
    rd(`TMOC_FLAG_OFS, 32'h0, 32'h1);
    tick(1);
    rd(`TMOC_CNT_OFS, 32'h0, 32'h0000_00FF);
    rd(`TMOC_FLAG_OFS, 32'h1, 32'h1);
    chk({31'h0, overflow_irq}, 32'h1);
    ack(1'b1);
    chk({31'h0, overflow_irq}, 32'h0);
  endtask : s_normal
  // counter write blocks the next match and beats a same-cycle tick
  task s_block;
    wr(`TMOC_FLAG_OFS, 32'h3);
    wr(`TMOC_CTRL_OFS, cfg(`TMOC_WGM_CTC, `TMOC_COM_TOGGLE, 3'h1, 1'b0, 1'b0));
    wr(`TMOC_CMP_OFS, 32'h3);
    wr(`TMOC_CNT_OFS, 32'h3);
    tick(1);
    rd(`TMOC_CNT_OFS, 32'h4, 32'h0000_00FF);
    rd(`TMOC_FLAG_OFS, 32'h0, 32'h2);
    fork
      wr(`TMOC_CNT_OFS, 32'h0000_0020);
      begin
        repeat (2) @(posedge pclk);
        timer_tick <= 1'b1;
        @(posedge pclk);
        timer_tick <= 1'b0;
      end
    join
    rd(`TMOC_CNT_OFS, 32'h0000_0020, 32'h0000_00FF);
    wr(`TMOC_CTRL_OFS, cfg(`TMOC_WGM_CTC, `TMOC_COM_TOGGLE, 3'h0, 1'b0, 1'b0));
    tick(3);
    rd(`TMOC_CNT_OFS, 32'h0000_0020, 32'h0000_00FF);
    wr(`TMOC_CNT_OFS, 32'h0000_0021);
    rd(`TMOC_CNT_OFS, 32'h0000_0021, 32'h0000_00FF);
  endtask : s_block
  // fast pwm: compare writes land in the buffer, active copy loads at max
  task s_pwm;
    wr(`TMOC_CTRL_OFS, cfg(`TMOC_WGM_NORMAL, `TMOC_COM_NONE, 3'h1, 1'b0, 1'b0));
    wr(`TMOC_CMP_OFS, 32'h0000_0010);
    wr(`TMOC_CTRL_OFS, cfg(`TMOC_WGM_FPWM, `TMOC_COM_NONE, 3'h1, 1'b0, 1'b0));
    wr(`TMOC_CMP_OFS, 32'h0000_0020);
    rd(`TMOC_CMP_OFS, 32'h0000_0020, 32'h0000_00FF);
    wr(`TMOC_CNT_OFS, 32'h0000_001F);
    wr(`TMOC_FLAG_OFS, 32'h3);
    tick(2);
    rd(`TMOC_FLAG_OFS, 32'h0, 32'h2);
    wr(`TMOC_CNT_OFS, 32'h0000_00FF);
    tick(34);
    rd(`TMOC_CNT_OFS, 32'h0000_0021, 32'h0000_00FF);
    rd(`TMOC_FLAG_OFS, 32'h3, 32'h3);
  endtask : s_pwm
  //////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    s_reset;
    s_force;
    s_ctc;
    s_normal;
    s_block;
    s_pwm;
    tally_and_finish;
  end
endmodule : tb
